// File: pfcd_ctrl.sv
// host-side command sequencer for an asynchronous x16 parallel flash
// Contract
// - wp may stay low outside boot block
// - drive wp high for boot-block program/erase
// - upper data byte driven valid in commands
// - erase final cycle carries sector/block address
// - buffer words repeat the fifth cycle
// - buffered words share A21-A4 with first
// - word count field is words minus one
// - security entry writes 88H to 555H
`timescale 1ns/1ps
module pfcd_ctrl
	import pfcd_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          arst_n,
	input  wire logic          cmd_valid,
	input  wire pfcd_cmd_type  cmd,
	output logic               cmd_ready,
	input  wire logic          wr_valid,
	input  wire logic [21:0]   wr_addr,
	input  wire logic [15:0]   wr_data,
	output logic               wr_ready,
	output logic               rsp_valid,
	output logic [15:0]        rsp_data,
	output logic               rsp_err,
	output pfcd_mode_type      mode,
	output logic               flash_ready,
	output pfcd_pins_type      flash_pins,
	input  wire logic [15:0]   flash_dq_in,
	input  wire logic          ready_busy_n
);

	typedef enum logic [2:0] {
		S_IDLE, S_WAITRDY, S_LAUNCH, S_CYCLE, S_BUFWORD, S_BUFCYC, S_RST_LOW, S_RST_REC
	} pfcd_state_type;

	pfcd_state_type state_r;
	pfcd_cmd_type   cmd_r;
	pfcd_cyc_type   cyc;
	logic [3:0]     step_r;
	logic [3:0]     wleft_r;
	logic [17:0]    base_r;
	logic           first_r;
	logic [21:0]    waddr_r;
	logic [15:0]    wdata_r;
	logic           start_r;
	logic [8:0]     rcnt_r;
	logic           rst_pin_r;
	logic           wp_n_r;
	logic [15:0]    dq_meta_r;
	logic [15:0]    dq_sync_r;
	logic           rb_meta_r;
	logic           eng_done;
	logic [15:0]    eng_rdata;
	logic           eng_ce_n;
	logic           eng_oe_n;
	logic           eng_we_n;
	logic [21:0]    eng_addr;
	logic [15:0]    eng_dq;
	logic           eng_dq_oe_n;
	logic           accept;
	logic           refuse;
	logic           fin;

	// command cycle on the low address lines, upper lines and byte at zero
	function automatic pfcd_cyc_type cw(input logic [10:0] a, input logic [7:0] d);
		pfcd_cyc_type c;
		c      = '0;
		c.addr = {11'h000, a};
		c.data = {8'h00, d};
		return c;
	endfunction : cw

	// bus cycle for a given operation and step
	function automatic pfcd_cyc_type cyc_of(input pfcd_cmd_type k, input logic [3:0] step,
		input logic byp);
		pfcd_cyc_type c;
		logic         unl;
		logic [3:0]   r;
		logic [7:0]   ecode;
		c     = '0;
		unl   = !byp && (k.op inside {OP_WORD_PROG, OP_BUF_PROG, OP_SECT_ERASE,
			OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_BYPASS_ENTRY, OP_ABORT_RESET,
			OP_SECID_ENTRY, OP_ID_ENTRY});
		r     = unl ? step - 4'd2 : step;
		ecode = (k.op == OP_SECT_ERASE) ? CODE_SECT_ERASE :
			(k.op == OP_BLOCK_ERASE) ? CODE_BLOCK_ERASE : CODE_CHIP_ERASE;
		if (unl && step < 4'd2) begin
			c = (step == 4'd0) ? cw(ADDR_UNLOCK1, CODE_UNLOCK1) : cw(ADDR_UNLOCK2, CODE_UNLOCK2);
		end else begin
			case (k.op)
				OP_READ: begin
					c.addr = {k.addr[21:2], k.addr[1:0] + step[1:0]};
					c.rd   = 1'b1;
					c.last = (step[1:0] == k.count[1:0]);
				end
				OP_WORD_PROG: begin
					if (r == 4'd0) begin
						c = cw(byp ? ADDR_ANY : ADDR_UNLOCK1, CODE_PROGRAM);
					end else begin
						c.addr = k.addr;
						c.data = k.data;
						c.last = 1'b1;
					end
				end
				OP_BUF_PROG: begin
					if (r == 4'd0) begin
						c = cw(ADDR_ANY, CODE_BUF_LOAD);
						c.addr = k.addr;
					end else if (r == 4'd1) begin
						c.addr = k.addr;
						c.data = {12'h000, k.count};
					end else begin
						c = cw(ADDR_ANY, CODE_BUF_CONFIRM);
						c.addr = k.addr;
						c.last = 1'b1;
					end
				end
				OP_SECT_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
					if (byp) begin
						c = (r == 4'd0) ? cw(ADDR_ANY, CODE_ERASE_SETUP) : cw(ADDR_ANY, ecode);
					end else begin
						case (r)
							4'd0: c = cw(ADDR_UNLOCK1, CODE_ERASE_SETUP);
							4'd1: c = cw(ADDR_UNLOCK1, CODE_UNLOCK1);
							4'd2: c = cw(ADDR_UNLOCK2, CODE_UNLOCK2);
							default: c = cw(ADDR_UNLOCK1, ecode);
						endcase
					end
					// last cycle carries sector or block address, chip erase leaves it
					if ((byp && r == 4'd1) || (!byp && r == 4'd3)) begin
						if (k.op != OP_CHIP_ERASE) begin
							c.addr = k.addr;
						end
						c.last = 1'b1;
					end
				end
				OP_BYPASS_EXIT: begin
					c      = (r == 4'd0) ? cw(ADDR_ANY, CODE_BYP_EXIT1) : cw(ADDR_ANY, CODE_BYP_EXIT2);
					c.last = (r == 4'd1);
				end
				OP_BYPASS_ENTRY: c = cw(ADDR_UNLOCK1, CODE_BYP_ENTRY);
				OP_ABORT_RESET:  c = cw(ADDR_UNLOCK1, CODE_ABORT_RST);
				OP_SECID_ENTRY:  c = cw(ADDR_UNLOCK1, CODE_SECID_ENTRY);
				OP_ID_ENTRY:     c = cw(ADDR_UNLOCK1, CODE_ID_ENTRY);
				OP_SUSPEND:      c = cw(ADDR_ANY, CODE_SUSPEND);
				OP_RESUME:       c = cw(ADDR_ANY, CODE_RESUME);
				OP_QUERY_ENTRY:  c = cw(ADDR_QUERY, CODE_QUERY_ENTRY);
				default:         c = cw(ADDR_ANY, CODE_MODE_EXIT);
			endcase
			if (!(k.op inside {OP_READ, OP_WORD_PROG, OP_BUF_PROG, OP_SECT_ERASE,
				OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_BYPASS_EXIT})) begin
				c.last = 1'b1;
			end
		end
		return c;
	endfunction : cyc_of

	// decode of the pending command and its refusal
	always_comb begin
		cyc    = cyc_of(cmd_r, step_r, mode.bypass);
		accept = cmd_valid && cmd_ready;
		refuse = (mode.bypass && !(cmd.op inside {OP_READ, OP_WORD_PROG, OP_SECT_ERASE,
			OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_BYPASS_EXIT,
			OP_HW_RESET}))
			|| (!mode.bypass && cmd.op == OP_BYPASS_EXIT)
			|| (mode.secid && cmd.op == OP_WORD_PROG
			&& (cmd.addr < SECID_USR_LO || cmd.addr > SECID_USR_HI));
		fin    = (state_r == S_CYCLE) && eng_done && cyc.last;
	end

	// pin input synchronisers, first stage read only by the second
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dq_meta_r   <= 16'h0000;
			dq_sync_r   <= 16'h0000;
			rb_meta_r   <= 1'b0;
			flash_ready <= 1'b0;
		end else begin
			dq_meta_r   <= flash_dq_in;
			dq_sync_r   <= dq_meta_r;
			rb_meta_r   <= ready_busy_n;
			flash_ready <= rb_meta_r;
		end
	end

	// main sequencer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= S_IDLE;
			cmd_r     <= '0;
			step_r    <= 4'h0;
			wleft_r   <= 4'h0;
			base_r    <= 18'h00000;
			first_r   <= 1'b0;
			waddr_r   <= 22'h000000;
			wdata_r   <= 16'h0000;
			start_r   <= 1'b0;
			rcnt_r    <= 9'h000;
			cmd_ready <= 1'b0;
			wr_ready  <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= 16'h0000;
			rsp_err   <= 1'b0;
		end else begin
			start_r   <= 1'b0;
			rsp_valid <= 1'b0;
			case (state_r)
				S_IDLE: begin
					cmd_ready <= 1'b1;
					if (accept) begin
						cmd_ready <= 1'b0;
						cmd_r     <= cmd;
						step_r    <= 4'h0;
						wleft_r   <= cmd.count;
						rsp_err   <= refuse;
						if (refuse) begin
							rsp_valid <= 1'b1;
						end else if (cmd.op == OP_HW_RESET) begin
							state_r <= S_RST_LOW;
							rcnt_r  <= 9'(RP_CYC - 1);
						end else if (cmd.op == OP_QUERY_EXIT) begin
							state_r <= S_WAITRDY;
						end else begin
							state_r <= S_LAUNCH;
						end
					end
				end
				S_WAITRDY: begin
					// exit would be ignored while the device is programming or erasing
					if (flash_ready) begin
						state_r <= S_LAUNCH;
					end
				end
				S_LAUNCH: begin
					start_r <= 1'b1;
					state_r <= S_CYCLE;
				end
				S_CYCLE: begin
					if (eng_done) begin
						if (cyc.rd) begin
							rsp_valid <= 1'b1;
							rsp_data  <= eng_rdata;
						end
						if (cyc.last) begin
							rsp_valid <= 1'b1;
							state_r   <= S_IDLE;
						end else if (cmd_r.op == OP_BUF_PROG && step_r == 4'd3) begin
							state_r  <= S_BUFWORD;
							wr_ready <= 1'b1;
							first_r  <= 1'b1;
						end else begin
							step_r  <= step_r + 4'h1;
							state_r <= S_LAUNCH;
						end
					end
				end
				S_BUFWORD: begin
					if (wr_valid && wr_ready) begin
						wr_ready <= 1'b0;
						if (!first_r && wr_addr[21:4] != base_r) begin
							// stray word: stop before the confirm, software must abort-reset
							rsp_err   <= 1'b1;
							rsp_valid <= 1'b1;
							state_r   <= S_IDLE;
						end else begin
							base_r  <= wr_addr[21:4];
							first_r <= 1'b0;
							waddr_r <= wr_addr;
							wdata_r <= wr_data;
							start_r <= 1'b1;
							state_r <= S_BUFCYC;
						end
					end
				end
				S_BUFCYC: begin
					if (eng_done) begin
						if (wleft_r == 4'h0) begin
							step_r  <= 4'd4;
							state_r <= S_LAUNCH;
						end else begin
							wleft_r  <= wleft_r - 4'h1;
							wr_ready <= 1'b1;
							state_r  <= S_BUFWORD;
						end
					end
				end
				S_RST_LOW: begin
					if (rcnt_r == 9'h000) begin
						state_r <= S_RST_REC;
						rcnt_r  <= 9'(RH_CYC - 1);
					end else begin
						rcnt_r <= rcnt_r - 9'h001;
					end
				end
				S_RST_REC: begin
					if (rcnt_r == 9'h000) begin
						rsp_valid <= 1'b1;
						state_r   <= S_IDLE;
					end else begin
						rcnt_r <= rcnt_r - 9'h001;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// reset pin and boot-block protect drive
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_pin_r <= 1'b0;
			wp_n_r    <= 1'b0;
		end else begin
			rst_pin_r <= !(state_r == S_RST_LOW);
			if (accept) begin
				// protect stays on unless a program or erase targets the boot block or the command is a chip erase
				wp_n_r <= (cmd.op inside {OP_WORD_PROG, OP_BUF_PROG, OP_SECT_ERASE,
					OP_BLOCK_ERASE} && cmd.addr < BOOT_LIMIT)
					|| cmd.op == OP_CHIP_ERASE;
			end
		end
	end

	// mode tracking mirrors the device; a hardware reset returns it to read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= '0;
		end else if (state_r == S_RST_LOW) begin
			mode <= '0;
		end else if (fin) begin
			case (cmd_r.op)
				OP_BYPASS_ENTRY: mode.bypass <= 1'b1;
				OP_BYPASS_EXIT:  mode.bypass <= 1'b0;
				OP_SECID_ENTRY:  mode.secid  <= 1'b1;
				OP_SECID_EXIT:   mode.secid  <= 1'b0;
				OP_ID_ENTRY:     mode.ident  <= 1'b1;
				OP_ID_EXIT:      mode.ident  <= 1'b0;
				OP_QUERY_ENTRY:  mode.query  <= 1'b1;
				OP_QUERY_EXIT:   mode.query  <= 1'b0;
				default:         mode        <= mode;
			endcase
		end
	end

	pfcd_bus_cycle u_cycle (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.start    (start_r),
		.rd       (state_r == S_CYCLE && cyc.rd),
		.addr     ((state_r == S_BUFCYC) ? waddr_r : cyc.addr),
		.wdata    ((state_r == S_BUFCYC) ? wdata_r : cyc.data),
		.dq_sync  (dq_sync_r),
		.done     (eng_done),
		.rdata    (eng_rdata),
		.ce_n     (eng_ce_n),
		.oe_n     (eng_oe_n),
		.we_n     (eng_we_n),
		.bus_addr (eng_addr),
		.dq_out   (eng_dq),
		.dq_oe_n  (eng_dq_oe_n)
	);

	// pin bundle, every field a flip-flop
	assign flash_pins = '{ce_n: eng_ce_n, oe_n: eng_oe_n, we_n: eng_we_n, rst_n: rst_pin_r,
		wp_n: wp_n_r, addr: eng_addr, dq_out: eng_dq, dq_oe_n: eng_dq_oe_n};

endmodule : pfcd_ctrl

// File: pfcd_pkg.sv
// shared constants, command codes and carrier types for the flash controller
package pfcd_pkg;

	// clock and pin timing, times in ns, counts rounded up
	localparam int CLK_NS      = 4;
	localparam int T_AS_NS     = 10;
	localparam int T_WP_NS     = 40;
	localparam int T_WH_NS     = 30;
	localparam int T_ACC_NS    = 100;
	localparam int T_RP_NS     = 500;
	localparam int T_RH_NS     = 1000;
	localparam int SYNC_STAGES = 2;
	localparam int SETUP_CYC   = (T_AS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC      = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC    = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam int RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC      = (T_RH_NS + CLK_NS - 1) / CLK_NS;

	// command cycle addresses, only the low eleven bits matter
	localparam logic [10:0] ADDR_UNLOCK1 = 11'h555;
	localparam logic [10:0] ADDR_UNLOCK2 = 11'h2aa;
	localparam logic [10:0] ADDR_QUERY   = 11'h055;
	localparam logic [10:0] ADDR_ANY     = 11'h000;

	// command data codes
	localparam logic [7:0] CODE_UNLOCK1    = 8'haa;
	localparam logic [7:0] CODE_UNLOCK2    = 8'h55;
	localparam logic [7:0] CODE_PROGRAM    = 8'ha0;
	localparam logic [7:0] CODE_BUF_LOAD   = 8'h25;
	localparam logic [7:0] CODE_BUF_CONFIRM = 8'h29;
	localparam logic [7:0] CODE_ABORT_RST  = 8'hf0;
	localparam logic [7:0] CODE_BYP_ENTRY  = 8'h20;
	localparam logic [7:0] CODE_BYP_EXIT1  = 8'h90;
	localparam logic [7:0] CODE_BYP_EXIT2  = 8'h00;
	localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CODE_SECT_ERASE = 8'h50;
	localparam logic [7:0] CODE_BLOCK_ERASE = 8'h30;
	localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CODE_SUSPEND    = 8'hb0;
	localparam logic [7:0] CODE_RESUME     = 8'h30;
	localparam logic [7:0] CODE_SECID_ENTRY = 8'h88;
	localparam logic [7:0] CODE_ID_ENTRY   = 8'h90;
	localparam logic [7:0] CODE_QUERY_ENTRY = 8'h98;
	localparam logic [7:0] CODE_MODE_EXIT  = 8'hf0;

	// address windows
	localparam logic [21:0] BOOT_LIMIT   = 22'h008000;
	localparam logic [21:0] SECID_USR_LO = 22'h000100;
	localparam logic [21:0] SECID_USR_HI = 22'h0001ff;

	typedef enum logic [4:0] {
		OP_READ, OP_WORD_PROG, OP_BUF_PROG, OP_SECT_ERASE, OP_BLOCK_ERASE,
		OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_BYPASS_ENTRY, OP_BYPASS_EXIT,
		OP_ABORT_RESET, OP_SECID_ENTRY, OP_SECID_EXIT, OP_ID_ENTRY, OP_ID_EXIT,
		OP_QUERY_ENTRY, OP_QUERY_EXIT, OP_HW_RESET
	} pfcd_op_type;

	typedef struct packed {
		pfcd_op_type op;
		logic [21:0] addr;
		logic [15:0] data;
		logic [3:0]  count;
	} pfcd_cmd_type;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        rst_n;
		logic        wp_n;
		logic [21:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe_n;
	} pfcd_pins_type;

	typedef struct packed {
		logic bypass;
		logic secid;
		logic ident;
		logic query;
	} pfcd_mode_type;

	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
		logic        rd;
		logic        last;
	} pfcd_cyc_type;

endpackage : pfcd_pkg

// File: pfcd_bus_cycle.sv
// single asynchronous read or write bus cycle on the flash pins
`timescale 1ns/1ps
module pfcd_bus_cycle
	import pfcd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        start,
	input  wire logic        rd,
	input  wire logic [21:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] dq_sync,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic [21:0]      bus_addr,
	output logic [15:0]      dq_out,
	output logic             dq_oe_n
);

	typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} pfcd_bc_type;

	pfcd_bc_type state_r;
	logic [7:0]  cnt_r;
	logic        rd_r;

	// phase sequencing and pin levels; oe and we are never low together
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r  <= BC_IDLE;
			cnt_r    <= 8'h00;
			rd_r     <= 1'b0;
			ce_n     <= 1'b1;
			oe_n     <= 1'b1;
			we_n     <= 1'b1;
			bus_addr <= 22'h000000;
			dq_out   <= 16'h0000;
			dq_oe_n  <= 1'b1;
		end else begin
			case (state_r)
				BC_IDLE: begin
					if (start) begin
						state_r  <= BC_SETUP;
						cnt_r    <= 8'(SETUP_CYC - 1);
						rd_r     <= rd;
						ce_n     <= 1'b0;
						bus_addr <= addr;
						dq_out   <= wdata;
						dq_oe_n  <= rd;
					end
				end
				BC_SETUP: begin
					if (cnt_r == 8'h00) begin
						state_r <= BC_STROBE;
						cnt_r   <= rd_r ? 8'(RD_CYC - 1) : 8'(WP_CYC - 1);
						we_n    <= rd_r;
						oe_n    <= !rd_r;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				BC_STROBE: begin
					if (cnt_r == 8'h00) begin
						state_r <= BC_HOLD;
						cnt_r   <= 8'(HOLD_CYC - 1);
						we_n    <= 1'b1;
						oe_n    <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				BC_HOLD: begin
					// address and data held past the strobe edge where the device latches
					if (cnt_r == 8'h00) begin
						state_r <= BC_IDLE;
						ce_n    <= 1'b1;
						dq_oe_n <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default: state_r <= BC_IDLE;
			endcase
		end
	end

	// read capture at the end of the strobe, sync latency already counted in
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 16'h0000;
		end else if (state_r == BC_STROBE && cnt_r == 8'h00 && rd_r) begin
			rdata <= dq_sync;
		end
	end

	// one-cycle completion pulse
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			done <= 1'b0;
		end else begin
			done <= (state_r == BC_HOLD && cnt_r == 8'h00);
		end
	end

endmodule : pfcd_bus_cycle

// File: pfcd_assertions.sv
// concurrent checks on the flash command sequencer ports
`timescale 1ns/1ps
module pfcd_ctrl_chk
	import pfcd_pkg::*;
(
	input wire logic          mclk,
	input wire logic          arst_n,
	input wire logic          cmd_valid,
	input wire pfcd_cmd_type  cmd,
	input wire logic          cmd_ready,
	input wire logic          rsp_valid,
	input wire logic          rsp_err,
	input wire pfcd_mode_type mode,
	input wire pfcd_pins_type flash_pins
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// a command is taken on this cycle
	logic take;
	assign take = cmd_valid && cmd_ready;

	property p_strobe_excl; !(!flash_pins.ce_n && !flash_pins.oe_n && !flash_pins.we_n); endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes overlap");
	property p_rd_release; !flash_pins.oe_n |-> flash_pins.dq_oe_n; endproperty
	a_rd_release: assert property (p_rd_release) else $error("host drives dq during read");
	// strobe low time, counted
	logic [7:0] we_lo_r;
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n) we_lo_r <= 8'h00;
		else we_lo_r <= flash_pins.we_n ? 8'h00 : we_lo_r + 8'h01;
	property p_we_width; $rose(flash_pins.we_n) |-> we_lo_r == 8'(WP_CYC); endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
	// address and data still while strobe low
	property p_we_hold; !flash_pins.we_n && !$fell(flash_pins.we_n) |->
		$stable(flash_pins.addr) && $stable(flash_pins.dq_out) && !flash_pins.dq_oe_n; endproperty
	a_we_hold: assert property (p_we_hold) else $error("write cycle not held");
	property p_exit_ref; take && cmd.op == OP_BYPASS_EXIT && !mode.bypass |=> rsp_valid && rsp_err;
	endproperty
	a_exit_ref: assert property (p_exit_ref) else $error("stray bypass exit accepted");
	property p_byp_ref; take && mode.bypass && cmd.op == OP_ID_ENTRY |=>
		rsp_valid && rsp_err && flash_pins.ce_n; endproperty
	a_byp_ref: assert property (p_byp_ref) else $error("bypass accepted a foreign command");
	property p_sid_ref; take && mode.secid && cmd.op == OP_WORD_PROG &&
		!(cmd.addr inside {[SECID_USR_LO:SECID_USR_HI]}) |=> rsp_valid && rsp_err; endproperty
	a_sid_ref: assert property (p_sid_ref) else $error("security program out of range");
	property p_wp_prog; take && cmd.op == OP_WORD_PROG && !mode.secid |=>
		flash_pins.wp_n == ($past(cmd.addr) < BOOT_LIMIT); endproperty
	a_wp_prog: assert property (p_wp_prog) else $error("write protect level wrong");
	property p_wp_chip; take && cmd.op == OP_CHIP_ERASE |=> flash_pins.wp_n; endproperty
	a_wp_chip: assert property (p_wp_chip) else $error("chip erase with protect low");
	c_buf: cover property (take && cmd.op == OP_BUF_PROG);
	c_err: cover property (rsp_valid && rsp_err);
	c_ident: cover property (mode.ident);
endmodule : pfcd_ctrl_chk

bind pfcd_ctrl pfcd_ctrl_chk u_pfcd_ctrl_chk (.mclk(mclk), .arst_n(arst_n),
	.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
	.rsp_err(rsp_err), .mode(mode), .flash_pins(flash_pins));

// File: pfcd_flash_model.sv
// behavioural flash device: write decode, array and id reads, busy line
`timescale 1ns/1ps
module pfcd_flash_model
	import pfcd_pkg::*;
#(
	parameter logic [15:0] MAKER = 16'h00a5, // arbitrary value
	parameter logic [15:0] PART  = 16'h1234, // arbitrary value
	parameter int          BUSY  = 300
)(
	input  wire logic          mclk,
	input  wire pfcd_pins_type pins,
	output logic [15:0]        dq_drv,
	output logic               rb_low
);
	logic [7:0]  h1;
	logic [7:0]  h2;
	logic        ident = 1'b0, sid = 1'b0;
	logic [15:0] last  = 16'h0;
	int          busy  = 0;
	// write taken on the strobe's rising edge; only low address bits decoded for commands, full address for the boot check
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.oe_n && pins.rst_n) begin
			if (h2 == 8'haa && h1 == 8'h55 && pins.addr[10:0] == 11'h555) begin
				ident |= pins.dq_out[7:0] == 8'h90;
				sid |= pins.dq_out[7:0] == 8'h88;
			end
			if (pins.dq_out[7:0] == 8'hf0) {ident, sid} = 2'b00;
			// boot block stays untouched while protect is low
			if (h1 == 8'ha0 && (pins.wp_n || pins.addr >= BOOT_LIMIT)) busy = BUSY;
			h2 = h1;
			h1 = pins.dq_out[7:0];
		end
	end
	// busy line, open drain, pulled up by the bench
	always @(posedge mclk) begin
		if (busy > 0) busy--;
		rb_low <= busy > 0;
		if (!pins.ce_n && !pins.oe_n) last <= dq_drv;
		if (!pins.rst_n) {ident, sid} = 2'b00;
	end
	// drive only during a read, else show the inverse of the last word
	always @* begin
		if (!pins.ce_n && !pins.oe_n && pins.we_n && pins.rst_n)
			dq_drv = sid ? (&pins.addr[7:0] ? 16'h0008 : {16{pins.addr[8]}})
				: ident && pins.addr[21:1] == '0 ? (pins.addr[0] ? PART : MAKER)
				: pins.addr[15:0] ^ 16'h3c3c;
		else
			dq_drv = ~last;
	end
endmodule : pfcd_flash_model

// File: parallel_flash_command_decoder_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module parallel_flash_command_decoder_tb
	import pfcd_pkg::*;
;
	localparam logic [15:0] MK = 16'h00a5; // arbitrary value
	localparam logic [15:0] PT = 16'h1234; // arbitrary value
	logic          mclk = 1'b0;
	logic          arst_n = 1'b0;
	logic          cmd_valid = 1'b0;
	logic          wr_valid = 1'b0;
	pfcd_cmd_type  cmd = '0;
	logic [21:0]   wr_addr = '0;
	logic [15:0]   wr_data = '0;
	logic          cmd_ready, wr_ready, rsp_valid, rsp_err, flash_ready, rb_low, wp_seen, rb_seen;
	logic [15:0]   rsp_data, mdl_dq, dq, d;
	logic [21:0]   a;
	pfcd_mode_type mode;
	pfcd_pins_type pins;
	logic [38:0]   expq[$];
	logic [37:0]   gotq[$], wq[$];
	logic [16:0]   rq[$];
	int            n_mismatch = 0, checks = 0, i;
	integer        seed = 32'hec0a87b0;

	pfcd_ctrl u_pfcd_ctrl (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_ready(wr_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.mode(mode), .flash_ready(flash_ready), .flash_pins(pins), .flash_dq_in(dq),
		.ready_busy_n(~rb_low));
	pfcd_flash_model #(.MAKER(MK), .PART(PT)) u_pfcd_flash_model (.mclk(mclk), .pins(pins),
		.dq_drv(mdl_dq), .rb_low(rb_low));

	always #2 mclk = ~mclk;
	assign dq = pins.dq_oe_n ? mdl_dq : pins.dq_out;
	// record each completed write strobe as the device sees it
	always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n) begin
		gotq.push_back({pins.addr, dq});
		wp_seen = pins.wp_n;
		rb_seen = rb_low;
	end
	always @(posedge mclk) if (rsp_valid) rq.push_back({rsp_err, rsp_data});
	// buffered word stream; popped only on an accepted word
	always @(posedge mclk) begin
		if (wr_valid && wr_ready && wq.size() > 0) void'(wq.pop_front());
		#1 wr_valid = wq.size() > 0;
		if (wr_valid) {wr_addr, wr_data} = wq[0];
	end

	function automatic void ex(logic f, logic [21:0] ea, logic [15:0] ed);
		expq.push_back({f, ea, ed});
	endfunction : ex
	function automatic void unl();
		ex(1'b0, 22'h555, 16'h00aa);
		ex(1'b0, 22'h2aa, 16'h0055);
	endfunction : unl
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	// command cycles compare only the decoded low address bits
	task automatic chk_cyc();
		logic [38:0] e;
		logic [37:0] m;
		`CHK("cycles", expq.size(), gotq.size())
		while (expq.size() > 0 && gotq.size() > 0) begin
			e = expq.pop_front();
			m = e[38] ? '1 : 38'h7ff_ffff;
			`CHK("cycle", e[37:0] & m, gotq.pop_front() & m)
		end
		expq.delete();
	endtask : chk_cyc
	// hold the request until taken, then wait for idle
	task automatic do_cmd(pfcd_op_type op, logic [21:0] ca, logic [15:0] cd, logic [3:0] cc);
		int n;
		n = 0;
		rq.delete();
		gotq.delete();
		cmd = {op, ca, cd, cc};
		cmd_valid = 1'b1;
		do begin @(posedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 9000);
		#1 cmd_valid = 1'b0;
		do begin @(posedge mclk); n++; end while (cmd_ready !== 1'b1 && n < 9000);
		#1;
		if (n >= 9000) begin
			n_mismatch++;
			end_sim();
		end
	endtask : do_cmd

	initial begin
		repeat (10) @(posedge mclk);
		`CHK("rst_idle", 3'b011, {pins.rst_n, pins.ce_n, pins.dq_oe_n})
		#1 arst_n = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		for (i = 0; i < 2; i++) begin
			a = 22'($random(seed));
			d = 16'($random(seed));
			if (i == 0) a[21:15] = '0;
			else a[15] = 1'b1;
			unl();
			ex(1'b0, 22'h555, 16'h00a0);
			ex(1'b1, a, d);
			do_cmd(OP_WORD_PROG, a, d, 4'h0);
			chk_cyc();
			`CHK("wp_n", i == 0, wp_seen)
		end
		for (i = 0; i < 4; i++) begin
			a = 22'($random(seed));
			do_cmd(OP_READ, a, 16'h0, 4'(i));
			`CHK("nread", i + 1, rq.size())
			foreach (rq[k]) `CHK("rdata", {1'b0, a[15:2], 2'(a[1:0] + k)} ^ 17'h3c3c, rq[k])
		end
		for (i = 0; i < 3; i++) begin
			a = 22'($random(seed)) | 22'h8000;
			unl();
			ex(1'b0, 22'h555, 16'h0080);
			unl();
			ex(i < 2, i == 2 ? 22'h555 : a, i == 0 ? 16'h0050 : i == 1 ? 16'h0030 : 16'h0010);
			do_cmd(i == 0 ? OP_SECT_ERASE : i == 1 ? OP_BLOCK_ERASE : OP_CHIP_ERASE, a, 16'h0, 4'h0);
			chk_cyc();
		end
		// full sixteen-word buffer, words out of order
		a = 22'($random(seed)) & 22'h3ffff0;
		unl();
		ex(1'b0, a, 16'h0025);
		ex(1'b0, a, 16'h000f);
		for (i = 0; i < 16; i++) begin
			d = 16'($random(seed));
			wq.push_back({a | 22'(15 - i), d});
			ex(1'b1, a | 22'(15 - i), d);
		end
		ex(1'b0, a, 16'h0029);
		do_cmd(OP_BUF_PROG, a, 16'h0, 4'hf);
		chk_cyc();
		wq.push_back({a, 16'h1111});
		wq.push_back({a ^ 22'h10, 16'h2222});
		do_cmd(OP_BUF_PROG, a, 16'h0, 4'h1);
		`CHK("buf_mis", 2'b11, {rsp_err, gotq[$][15:0] !== 16'h0029})
		wq.delete();
		unl();
		ex(1'b0, 22'h555, 16'h00f0);
		do_cmd(OP_ABORT_RESET, 22'h0, 16'h0, 4'h0);
		chk_cyc();
		unl();
		ex(1'b0, 22'h555, 16'h0020);
		do_cmd(OP_BYPASS_ENTRY, 22'h0, 16'h0, 4'h0);
		chk_cyc();
		do_cmd(OP_ID_ENTRY, 22'h0, 16'h0, 4'h0);
		`CHK("byp_ref", 3'b111, {mode.bypass, rsp_err, gotq.size() == 0})
		do_cmd(OP_SUSPEND, 22'h0, 16'h0, 4'h0);
		`CHK("susp", 17'h000b0, {rsp_err, gotq[0][15:0]})
		do_cmd(OP_RESUME, 22'h0, 16'h0, 4'h0);
		`CHK("resume", 17'h00030, {rsp_err, gotq[0][15:0]})
		d = 16'($random(seed));
		do_cmd(OP_WORD_PROG, 22'h9000, d, 4'h0);
		`CHK("byp_wp", {16'h00a0, 22'h9000, d}, {gotq[0][15:0], gotq[1]})
		do_cmd(OP_BYPASS_EXIT, 22'h0, 16'h0, 4'h0);
		`CHK("byp_exit", 17'h00090, {mode.bypass, gotq[0][15:0]})
		do_cmd(OP_BYPASS_EXIT, 22'h0, 16'h0, 4'h0);
		`CHK("exit_ref", 1'b1, rsp_err)
		unl();
		ex(1'b0, 22'h555, 16'h0088);
		do_cmd(OP_SECID_ENTRY, 22'h0, 16'h0, 4'h0);
		chk_cyc();
		do_cmd(OP_WORD_PROG, 22'h0000ff, 16'h0, 4'h0);
		`CHK("sid_lo", 3'b111, {mode.secid, rsp_err, gotq.size() == 0})
		a = {14'h1, 8'($random(seed))};
		unl();
		ex(1'b0, 22'h555, 16'h00a0);
		ex(1'b1, a, d);
		do_cmd(OP_WORD_PROG, a, d, 4'h0);
		chk_cyc();
		do_cmd(OP_READ, 22'h1fe, 16'h0, 4'h1);
		`CHK("sid_rd", 32'hffff0008, {rq[0][15:0], rq[1][15:0]})
		do_cmd(OP_SECID_EXIT, 22'h0, 16'h0, 4'h0);
		`CHK("sid_exit", 1'b0, mode.secid)
		do_cmd(OP_ID_ENTRY, 22'h0, 16'h0, 4'h0);
		do_cmd(OP_READ, 22'h0, 16'h0, 4'h1);
		`CHK("ids", {1'b1, MK, PT}, {mode.ident, rq[0][15:0], rq[1][15:0]})
		do_cmd(OP_ID_EXIT, 22'h0, 16'h0, 4'h0);
		do_cmd(OP_READ, 22'h1, 16'h0, 4'h0);
		`CHK("id_exit", 16'h3c3d, rq[0][15:0])
		// device busy with a program while query exit is asked for
		do_cmd(OP_WORD_PROG, 22'h9000, 16'h1234, 4'h0);
		do_cmd(OP_QUERY_ENTRY, 22'h0, 16'h0, 4'h0);
		`CHK("query", 1'b1, mode.query)
		do_cmd(OP_QUERY_EXIT, 22'h0, 16'h0, 4'h0);
		`CHK("q_wait", 3'b001, {rb_seen, mode.query, flash_ready})
		do_cmd(OP_QUERY_ENTRY, 22'h0, 16'h0, 4'h0);
		do_cmd(OP_HW_RESET, 22'h0, 16'h0, 4'h0);
		`CHK("hw_rst", 5'h0, {mode, gotq.size() != 0})
		end_sim();
	end
endmodule : parallel_flash_command_decoder_tb
